// *** shared/dtw_pkg.sv ***
/*
  Constants for the dual timer and watchdog: register offsets, field
  positions, reset values, mode codes and watchdog counts.
  Assumes word-aligned byte offsets on the register port.
*/
`default_nettype none
package dtw_pkg;
  localparam logic [4:0] OFS_CSR0 = 5'h00;
  localparam logic [4:0] OFS_CSR1 = 5'h04;
  localparam logic [4:0] OFS_RELOAD0 = 5'h08;
  localparam logic [4:0] OFS_RELOAD1 = 5'h0c;
  localparam logic [4:0] OFS_LIVE0 = 5'h10;
  localparam logic [4:0] OFS_LIVE1 = 5'h14;
  localparam logic [4:0] OFS_FLAGS = 5'h18;
  localparam logic [4:0] OFS_WDCTL = 5'h1c;
  // Channel control/status fields
  localparam int CSR_OVR = 31;
  localparam int CSR_RUN = 30;
  localparam int CSR_IRQ = 29;
  localparam int CSR_MODE_HI = 28;
  localparam int CSR_MODE_LO = 27;
  localparam int CSR_CLR = 26;
  localparam int CSR_ACT = 25;
  localparam int CSR_PRE_HI = 7;
  localparam logic [7:0] PRESCALE_RST = 8'h05;
  localparam logic [1:0] MODE_ONESHOT = 2'h0;
  localparam logic [1:0] MODE_PERIODIC = 2'h1;
  localparam logic [1:0] MODE_TOGGLE = 2'h2;
  localparam logic [1:0] MODE_UNINT = 2'h3;
  // Watchdog control fields
  localparam int WD_SLOW = 10;
  localparam int WD_OVR = 9;
  localparam int WD_TEST = 8;
  localparam int WD_RUN = 7;
  localparam int WD_IRQ = 6;
  localparam int WD_IS_HI = 5;
  localparam int WD_IS_LO = 4;
  localparam int WD_TOF = 3;
  localparam int WD_RSF = 2;
  localparam int WD_RSA = 1;
  localparam int WD_RESTART = 0;
  localparam logic [31:0] WDCTL_RST = 32'h0000_0400;
  localparam logic [7:0] WD_DIV_LAST = 8'hff;
  localparam logic [13:0] WD_DELAY_CYC = 14'h0400;
  localparam logic [13:0] WD_RST_CYC = 14'h3f00;
  localparam int WD_MIN_EXP = 14;
  localparam logic [9:0] WD_HALF_LAST = 10'h3ff;
  localparam logic [1:0] RESTART_HOLD = 2'h3;
  typedef enum logic [1:0] {WD_COUNT, WD_DELAY, WD_RESET} dtw_wd_state_type;
endpackage
`default_nettype wire

// *** shared/dtw_chan_if.sv ***
/*
  Control and event bundle between the register block and one channel.
  Assumes both ends run on the crystal clock.
*/
`default_nettype none
interface dtw_chan_if;
  logic run;
  logic hold;
  logic [1:0] mode;
  logic [7:0] prescale;
  logic [31:0] reload;
  logic load;
  logic clr;
  logic [31:0] count;
  logic zero_evt;
  logic hit_evt;
  logic tout;
  modport ctl(output run, hold, mode, prescale, reload, load, clr,
    input count, zero_evt, hit_evt, tout);
  modport chan(input run, hold, mode, prescale, reload, load, clr,
    output count, zero_evt, hit_evt, tout);
endinterface
`default_nettype wire

// *** rtl/dtw_channel.sv ***
/*
  One down-counting timer channel with prescaler and toggle output.
  Assumes load and clr are single-cycle pulses from the register block.
*/
`default_nettype none
module dtw_channel (
  input wire logic clk_i,
  input wire logic rst_i,
  dtw_chan_if.chan ch
);
  import dtw_pkg::*;
  logic [7:0] pre_cnt;
  logic [31:0] count;
  logic [31:0] next_count;
  logic tick;
  logic tout;

  // Compare as at-or-above so a smaller prescale written mid-count cannot stall 256 clocks
  assign tick = ch.run && !ch.hold && (pre_cnt >= ch.prescale);
  assign next_count = (count <= 32'h1) ? ch.reload : count - 32'h1;
  assign ch.count = count;
  assign ch.zero_evt = tick && (count <= 32'h1);
  assign ch.hit_evt = tick && (next_count == ch.reload);
  assign ch.tout = tout;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pre_cnt <= 8'h00;
    end else if (ch.clr || ch.load) begin
      pre_cnt <= 8'h00;
    end else if (ch.run && !ch.hold) begin
      pre_cnt <= tick ? 8'h00 : pre_cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count <= 32'h0;
    end else if (ch.clr) begin
      count <= 32'h0;
    end else if (ch.load) begin
      count <= ch.reload;
    end else if (tick) begin
      count <= next_count;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tout <= 1'b0;
    end else if (ch.clr) begin
      tout <= 1'b0;
    end else if (ch.zero_evt && ch.mode == MODE_TOGGLE) begin
      tout <= !tout;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  reload_restart_a: assert property (ch.load && !ch.clr |=> count == $past(ch.reload))
    else $error("reload write did not restart count");
  zero_reload_a: assert property (ch.zero_evt && !ch.clr && !ch.load |=>
    count == $past(ch.reload))
    else $error("count did not reload at zero");
  prescale_hold_a: assert property (ch.run && pre_cnt < ch.prescale && !ch.clr && !ch.load
    |=> count == $past(count))
    else $error("count moved before prescale expiry");
endmodule
`default_nettype wire

// *** rtl/dtw_wd_tick.sv ***
/*
  Watchdog count enable: optional divide by 256 of the crystal clock.
  Assumes hold is already synchronised to the crystal clock.
*/
`default_nettype none
module dtw_wd_tick (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic slow_i,
  input wire logic test_i,
  input wire logic hold_i,
  output logic tick_o
);
  import dtw_pkg::*;
  logic [7:0] div;
  logic use_slow;

  assign use_slow = slow_i && !test_i;
  assign tick_o = run_i && !hold_i && (!use_slow || div == WD_DIV_LAST);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div <= 8'h00;
    end else if (!run_i) begin
      div <= 8'h00;
    end else if (!hold_i) begin
      div <= div + 8'h01;
    end
  end
endmodule
`default_nettype wire

// *** rtl/dtw_timer.sv ***
/*
  Dual timer with watchdog: register file, two channels, watchdog.
  Assumes a simple register port: writes and reads take effect on the
  clock edge where the strobe is high; read data appears one cycle later.
*/
`default_nettype none
module dtw_timer (
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic [4:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [31:0] REG_WDATA_I,
  output logic [31:0] REG_RDATA_O,
  input wire logic DEBUG_ACK_I,
  output logic [1:0] TMR_IRQ_O,
  output logic [1:0] TMR_TOGGLE_O,
  output logic WD_IRQ_O,
  output logic WD_RST_O
);
  import dtw_pkg::*;

  // Channel control
  logic [1:0] ovr;
  logic [1:0] count_run;
  logic [1:0] irq_allow;
  logic [1:0] mode [2];
  logic [7:0] prescale [2];
  logic [31:0] reload [2];
  logic [1:0] tflag;
  logic [1:0] csr_wr;
  logic [1:0] rel_wr;
  logic [1:0] chan_clr;
  logic [1:0] flag_set;
  logic [1:0] done;
  logic [1:0] active;
  logic [31:0] live [2];
  logic [1:0] zero_evt;
  logic [1:0] hit_evt;
  logic [1:0] tout;

  // Watchdog control
  logic wd_slow;
  logic wd_ovr;
  logic wd_test;
  logic wd_run;
  logic wd_irq_allow;
  logic [1:0] wd_isel;
  logic wd_tof;
  logic wd_rsf;
  logic wd_rsa;
  logic [1:0] restart_cnt;
  logic wd_restart;
  logic wd_tick;
  logic [19:0] wd_cnt;
  logic [19:0] wd_top;
  logic wd_timeout;
  logic [13:0] phase_cnt;
  logic enter_reset;
  dtw_wd_state_type wd_state;

  // Debug acknowledge synchroniser
  logic [2:0] dbg_sync;
  logic dbg_ack;

  logic wr_wdctl;

  function automatic logic [19:0] interval_top(input logic [1:0] sel);
    interval_top = 20'((32'h1 << (WD_MIN_EXP + 2 * int'(sel))) - 1);
  endfunction

  // Pin input, three stages; level moves only when stages two and three agree
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      dbg_sync <= 3'h0;
    end else begin
      dbg_sync <= {dbg_sync[1:0], DEBUG_ACK_I};
    end
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      dbg_ack <= 1'b0;
    end else if (dbg_sync[1] == dbg_sync[2]) begin
      dbg_ack <= dbg_sync[2];
    end
  end

  assign wr_wdctl = REG_WR_I && REG_ADDR_I == OFS_WDCTL;

  always_comb begin
    csr_wr[0] = REG_WR_I && REG_ADDR_I == OFS_CSR0;
    csr_wr[1] = REG_WR_I && REG_ADDR_I == OFS_CSR1;
    rel_wr[0] = REG_WR_I && REG_ADDR_I == OFS_RELOAD0;
    rel_wr[1] = REG_WR_I && REG_ADDR_I == OFS_RELOAD1;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_chan
      dtw_chan_if cbus();
      assign chan_clr[gi] = csr_wr[gi] && REG_WDATA_I[CSR_CLR];
      assign cbus.run = count_run[gi];
      assign cbus.hold = dbg_ack && !ovr[gi];
      assign cbus.mode = mode[gi];
      assign cbus.prescale = prescale[gi];
      // Write data forwarded so the restart loads the new value, not the old one
      assign cbus.reload = rel_wr[gi] ? REG_WDATA_I : reload[gi];
      assign cbus.load = rel_wr[gi];
      assign cbus.clr = chan_clr[gi];
      assign live[gi] = cbus.count;
      assign zero_evt[gi] = cbus.zero_evt;
      assign hit_evt[gi] = cbus.hit_evt;
      assign tout[gi] = cbus.tout;
      assign active[gi] = count_run[gi] && !cbus.hold;
      assign done[gi] = zero_evt[gi] && mode[gi] == MODE_ONESHOT;
      // Mode 11 flags on the count matching reload, others on reaching zero
      assign flag_set[gi] = irq_allow[gi] &&
        (mode[gi] == MODE_UNINT ? hit_evt[gi] : zero_evt[gi]);
      dtw_channel u_chan (
        .clk_i(MCLK_I),
        .rst_i(RST_I),
        .ch(cbus.chan)
      );
    end
  endgenerate

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      ovr <= 2'h0;
      irq_allow <= 2'h0;
      mode[0] <= MODE_ONESHOT;
      mode[1] <= MODE_ONESHOT;
      prescale[0] <= PRESCALE_RST;
      prescale[1] <= PRESCALE_RST;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (csr_wr[i]) begin
          ovr[i] <= REG_WDATA_I[CSR_OVR];
          irq_allow[i] <= REG_WDATA_I[CSR_IRQ];
          mode[i] <= REG_WDATA_I[CSR_MODE_HI:CSR_MODE_LO];
          prescale[i] <= REG_WDATA_I[CSR_PRE_HI:0];
        end
      end
    end
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      count_run <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (chan_clr[i]) begin
          count_run[i] <= 1'b0;
        end else if (csr_wr[i]) begin
          count_run[i] <= REG_WDATA_I[CSR_RUN];
        end else if (done[i]) begin
          count_run[i] <= 1'b0;
        end
      end
    end
  end

  // Zero of a reload stalls nothing here; software keeps it nonzero
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      reload[0] <= 32'h0;
      reload[1] <= 32'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (rel_wr[i]) begin
          reload[i] <= REG_WDATA_I;
        end
      end
    end
  end

  // Set wins over a same-cycle write-one clear
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      tflag <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (flag_set[i]) begin
          tflag[i] <= 1'b1;
        end else if (REG_WR_I && REG_ADDR_I == OFS_FLAGS && REG_WDATA_I[i]) begin
          tflag[i] <= 1'b0;
        end
      end
    end
  end

  assign TMR_IRQ_O = tflag;
  assign TMR_TOGGLE_O = tout;

  // Watchdog control register
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      wd_slow <= WDCTL_RST[WD_SLOW];
      wd_ovr <= WDCTL_RST[WD_OVR];
      wd_test <= WDCTL_RST[WD_TEST];
      wd_run <= WDCTL_RST[WD_RUN];
      wd_irq_allow <= WDCTL_RST[WD_IRQ];
      wd_isel <= WDCTL_RST[WD_IS_HI:WD_IS_LO];
      wd_rsa <= WDCTL_RST[WD_RSA];
    end else if (wr_wdctl) begin
      wd_slow <= REG_WDATA_I[WD_SLOW];
      wd_ovr <= REG_WDATA_I[WD_OVR];
      wd_test <= REG_WDATA_I[WD_TEST];
      wd_run <= REG_WDATA_I[WD_RUN];
      wd_irq_allow <= REG_WDATA_I[WD_IRQ];
      wd_isel <= REG_WDATA_I[WD_IS_HI:WD_IS_LO];
      wd_rsa <= REG_WDATA_I[WD_RSA];
    end
  end

  // Restart stays visible three cycles; the count clears on it whether or not a tick comes
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      restart_cnt <= 2'h0;
    end else if (wr_wdctl && REG_WDATA_I[WD_RESTART]) begin
      restart_cnt <= RESTART_HOLD;
    end else if (restart_cnt != 2'h0) begin
      restart_cnt <= restart_cnt - 2'h1;
    end
  end

  assign wd_restart = restart_cnt != 2'h0;

  dtw_wd_tick u_wd_tick (
    .clk_i(MCLK_I),
    .rst_i(RST_I),
    .run_i(wd_run),
    .slow_i(wd_slow),
    .test_i(wd_test),
    .hold_i(dbg_ack && !wd_ovr),
    .tick_o(wd_tick)
  );

  assign wd_top = interval_top(wd_isel);
  always_comb begin
    if (wd_test) begin
      wd_timeout = wd_tick && (wd_cnt[9:0] == WD_HALF_LAST ||
        wd_cnt[19:10] == WD_HALF_LAST);
    end else begin
      wd_timeout = wd_tick && wd_cnt == wd_top;
    end
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      wd_cnt <= 20'h0;
    end else if (!wd_run || wd_restart) begin
      wd_cnt <= 20'h0;
    end else if (wd_tick) begin
      if (wd_test) begin
        wd_cnt <= {wd_cnt[19:10] + 10'h1, wd_cnt[9:0] + 10'h1};
      end else if (wd_timeout) begin
        wd_cnt <= 20'h0;
      end else begin
        wd_cnt <= wd_cnt + 20'h1;
      end
    end
  end

  // Timeout, delay, then the reset pulse
  assign enter_reset = wd_state == WD_DELAY && wd_tick && phase_cnt == WD_DELAY_CYC - 14'h1;

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      wd_state <= WD_COUNT;
      phase_cnt <= 14'h0;
    end else if (!wd_run) begin
      wd_state <= WD_COUNT;
      phase_cnt <= 14'h0;
    end else begin
      case (wd_state)
        WD_COUNT: begin
          phase_cnt <= 14'h0;
          if (wd_timeout && wd_rsa) begin
            wd_state <= WD_DELAY;
          end
        end
        WD_DELAY: begin
          if (wd_restart) begin
            wd_state <= WD_COUNT;
          end else if (enter_reset) begin
            wd_state <= WD_RESET;
            phase_cnt <= 14'h0;
          end else if (wd_tick) begin
            phase_cnt <= phase_cnt + 14'h1;
          end
        end
        WD_RESET: begin
          if (wd_tick && phase_cnt == WD_RST_CYC - 14'h1) begin
            wd_state <= WD_COUNT;
            phase_cnt <= 14'h0;
          end else if (wd_tick) begin
            phase_cnt <= phase_cnt + 14'h1;
          end
        end
        default: begin
          wd_state <= WD_COUNT;
          phase_cnt <= 14'h0;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      wd_tof <= 1'b0;
    end else if (wd_timeout) begin
      wd_tof <= 1'b1;
    end else if (wr_wdctl && REG_WDATA_I[WD_TOF]) begin
      wd_tof <= 1'b0;
    end
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      wd_rsf <= 1'b0;
    end else if (enter_reset) begin
      wd_rsf <= 1'b1;
    end else if (wr_wdctl && REG_WDATA_I[WD_RSF]) begin
      wd_rsf <= 1'b0;
    end
  end

  assign WD_IRQ_O = wd_tof && wd_irq_allow;
  assign WD_RST_O = wd_state == WD_RESET;

  // Read data registered; unmapped offsets read zero
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      REG_RDATA_O <= 32'h0;
    end else if (REG_RD_I) begin
      case (REG_ADDR_I)
        OFS_CSR0: REG_RDATA_O <= {ovr[0], count_run[0], irq_allow[0], mode[0], 1'b0,
          active[0], 17'h0, prescale[0]};
        OFS_CSR1: REG_RDATA_O <= {ovr[1], count_run[1], irq_allow[1], mode[1], 1'b0,
          active[1], 17'h0, prescale[1]};
        OFS_RELOAD0: REG_RDATA_O <= reload[0];
        OFS_RELOAD1: REG_RDATA_O <= reload[1];
        OFS_LIVE0: REG_RDATA_O <= live[0];
        OFS_LIVE1: REG_RDATA_O <= live[1];
        OFS_FLAGS: REG_RDATA_O <= {30'h0, tflag};
        OFS_WDCTL: REG_RDATA_O <= {21'h0, wd_slow, wd_ovr, wd_test, wd_run, wd_irq_allow,
          wd_isel, wd_tof, wd_rsf, wd_rsa, wd_restart};
        default: REG_RDATA_O <= 32'h0;
      endcase
    end
  end

  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RST_I);

  sequence restart_hold_s;
    wd_restart [*3] ##1 !wd_restart;
  endsequence
  sequence restart_req_s;
    wr_wdctl && REG_WDATA_I[WD_RESTART];
  endsequence

  restart_self_clear_a: assert property (restart_req_s |=> restart_hold_s)
    else $error("restart bit did not self clear");
  flag_set_wins_a: assert property (flag_set[0] |=> tflag[0])
    else $error("channel flag lost on set");
  chan_clear_a: assert property (chan_clr[0] |=> !count_run[0] && live[0] == 32'h0)
    else $error("clear did not stop channel");
  wd_timeout_flag_a: assert property (wd_timeout |=> wd_tof)
    else $error("timeout flag not set");
  no_reset_gate_a: assert property (wd_state == WD_COUNT && !wd_rsa
    |=> wd_state == WD_COUNT)
    else $error("reset phase without reset allow");
  reset_flag_a: assert property ($rose(WD_RST_O) |-> wd_rsf)
    else $error("reset flag missing at reset");
  wd_hold_a: assert property (dbg_ack && !wd_ovr && wd_run && !wd_restart
    |=> wd_cnt == $past(wd_cnt))
    else $error("watchdog counted under debug hold");
  wd_stop_a: assert property (!wd_run |=> wd_cnt == 20'h0 && !WD_RST_O)
    else $error("watchdog not cleared by run off");
endmodule
`default_nettype wire

// *** verif/tb_dtw_timer.sv ***
/*
  Self-checking bench for the dual timer with watchdog.
  Assumes the plain strobe register port and a 50 MHz crystal clock.
*/
`default_nettype none
module tb_dtw_timer;
  timeunit 1ns;
  timeprecision 1ps;
  import dtw_pkg::*;
  logic mclk = 0;
  logic rst = 1;
  logic [4:0] addr = '0;
  logic wr_s = 0;
  logic rd_s = 0;
  logic [31:0] wdata = '0;
  logic [31:0] rdata;
  logic dbg = 0;
  logic [1:0] tirq;
  logic [1:0] tog;
  logic wirq;
  logic wrst;
  int fail_count = 0;
  int comparisons = 0;
  localparam logic [31:0] RUN = 32'h1 << CSR_RUN;
  localparam logic [31:0] IRQ = 32'h1 << CSR_IRQ;
  localparam logic [31:0] W_RUN = 32'h1 << WD_RUN;
  localparam logic [31:0] W_IRQ = 32'h1 << WD_IRQ;
  localparam logic [31:0] W_TST = 32'h1 << WD_TEST;
  localparam logic [31:0] W_FLG = 32'h0000_000c;

  dtw_timer dut (
    .MCLK_I(mclk),
    .RST_I(rst),
    .REG_ADDR_I(addr),
    .REG_WR_I(wr_s),
    .REG_RD_I(rd_s),
    .REG_WDATA_I(wdata),
    .REG_RDATA_O(rdata),
    .DEBUG_ACK_I(dbg),
    .TMR_IRQ_O(tirq),
    .TMR_TOGGLE_O(tog),
    .WD_IRQ_O(wirq),
    .WD_RST_O(wrst)
  );

  initial begin
    forever #10 mclk = ~mclk;
  end

  function automatic logic [31:0] md(logic [1:0] m);
    return {3'h0, m, 27'h0};
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(negedge mclk);
    addr = a;
    wdata = d;
    wr_s = 1;
    @(negedge mclk);
    wr_s = 0;
  endtask

  // Data is registered at the read edge, settled by the next falling edge
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(negedge mclk);
    addr = a;
    rd_s = 1;
    @(negedge mclk);
    rd_s = 0;
    d = rdata;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic near(input string nm, input int e, input int g, input int tol);
    comparisons++;
    if (g < e - tol || g > e + tol) begin
      fail_count++;
      $display("mismatch %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  function automatic logic pick(int w);
    case (w)
      0: return wirq;
      1: return wrst;
      2: return !wrst;
      3: return tirq[0];
      default: return tirq[1];
    endcase
  endfunction

  // Bounded wait, counts falling edges until the chosen output is high
  task automatic wait_sig(input int w, input int mx, output int n);
    n = 0;
    while (pick(w) !== 1'b1 && n < mx) begin
      @(negedge mclk);
      n++;
    end
  endtask

  // First interval is skipped: it may straddle a setting change
  task automatic tog_period(output int n);
    logic v;
    repeat (2) begin
      v = tog[1];
      n = 0;
      while (tog[1] === v && n < 100) begin
        @(negedge mclk);
        n++;
      end
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (95000) @(posedge mclk);
    fail_count++;
    $display("mismatch run length expected done seen hang");
    test_done();
  end

  initial begin
    logic [31:0] d;
    logic [4:0] ra [7] = '{OFS_CSR0, OFS_CSR1, OFS_RELOAD0, OFS_RELOAD1, OFS_LIVE1,
                           OFS_FLAGS, OFS_WDCTL};
    logic [31:0] rv [7] = '{32'h5, 32'h5, 32'h0, 32'h0, 32'h0, 32'h0, WDCTL_RST};
    int n;
    repeat (3) @(negedge mclk);
    rst = 0;
    foreach (ra[i]) begin
      rd(ra[i], d);
      chk("reset value", rv[i], d);
    end
    wr(OFS_LIVE1, 32'h1234);
    rd(OFS_LIVE1, d);
    chk("live count read only", 32'h0, d);
    wr(OFS_RELOAD0, 32'h7);
    rd(OFS_LIVE0, d);
    chk("reload while stopped", 32'h7, d);
    // Held by debug while running, then overridden; stopped before every live read
    dbg = 1;
    wr(OFS_CSR0, RUN | IRQ | md(MODE_PERIODIC));
    cyc(6);
    wr(OFS_RELOAD0, 32'd1000);
    rd(OFS_CSR0, d);
    chk("active while held", 32'h0, {31'h0, d[CSR_ACT]});
    wr(OFS_CSR0, IRQ | md(MODE_PERIODIC));
    rd(OFS_LIVE0, d);
    chk("reload while running", 32'd1000, d);
    wr(OFS_CSR0, (32'h1 << CSR_OVR) | RUN | IRQ | md(MODE_PERIODIC));
    cyc(20);
    wr(OFS_CSR0, (32'h1 << CSR_OVR) | IRQ | md(MODE_PERIODIC));
    rd(OFS_LIVE0, d);
    chk("count runs on override", 32'h1, {31'h0, d < 32'd1000});
    dbg = 0;
    wr(OFS_CSR0, RUN | (32'h1 << CSR_CLR));
    rd(OFS_CSR0, d);
    chk("control after clear", 32'h0, d);
    rd(OFS_LIVE0, d);
    chk("count after clear", 32'h0, d);
    wr(OFS_FLAGS, 32'h3);
    wr(OFS_RELOAD0, 32'h3);
    wr(OFS_CSR0, RUN | md(MODE_PERIODIC));
    cyc(20);
    chk("flag without allow", 32'h0, {30'h0, tirq});
    wr(OFS_CSR0, RUN | IRQ | md(MODE_UNINT));
    wait_sig(3, 20, n);
    chk("flag in mode 11", 32'h1, {31'h0, tirq[0]});
    wr(OFS_CSR0, 32'h0);
    wr(OFS_FLAGS, 32'h0);
    chk("flag kept on zero write", 32'h1, {31'h0, tirq[0]});
    wr(OFS_FLAGS, 32'h1);
    rd(OFS_FLAGS, d);
    chk("flag cleared by one", 32'h0, d);
    wr(OFS_CSR0, RUN | IRQ | md(MODE_ONESHOT));
    wait_sig(3, 20, n);
    cyc(3);
    rd(OFS_CSR0, d);
    chk("one shot stops", 32'h0, {31'h0, d[CSR_RUN]});
    wr(OFS_FLAGS, 32'h1);
    cyc(20);
    chk("one shot fires once", 32'h0, {31'h0, tirq[0]});
    wr(OFS_RELOAD1, 32'h4);
    wr(OFS_CSR1, RUN | IRQ | md(MODE_TOGGLE) | 32'h2);
    tog_period(n);
    near("toggle period", 12, n, 0);
    chk("channel 1 flag", 32'h1, {31'h0, tirq[1]});
    chk("channel 0 toggle idle", 32'h0, {31'h0, tog[0]});
    wr(OFS_CSR1, RUN | IRQ | md(MODE_TOGGLE));
    tog_period(n);
    near("toggle period", 4, n, 0);
    wr(OFS_CSR1, 32'h0);
    wr(OFS_FLAGS, 32'h2);
    chk("channel 1 flag clear", 32'h0, {30'h0, tirq});
    wr(OFS_WDCTL, W_FLG);
    wr(OFS_WDCTL, W_RUN | W_IRQ);
    wait_sig(0, 17000, n);
    near("timeout cycles", 16384, n, 4);
    cyc(1100);
    chk("no reset when disallowed", 32'h0, {31'h0, wrst});
    wr(OFS_WDCTL, W_RUN);
    rd(OFS_WDCTL, d);
    chk("flags without allow", 32'h8, {28'h0, d[3:0]});
    chk("interrupt gated", 32'h0, {31'h0, wirq});
    wr(OFS_WDCTL, W_FLG);
    wr(OFS_WDCTL, W_RUN | W_IRQ | 32'h2);
    cyc(2000);
    wr(OFS_WDCTL, W_RUN | W_IRQ | 32'h3);
    rd(OFS_WDCTL, d);
    chk("restart pending", 32'h1, {31'h0, d[WD_RESTART]});
    cyc(10);
    rd(OFS_WDCTL, d);
    chk("restart self clear", 32'h0, {31'h0, d[WD_RESTART]});
    // Past the unrestarted timeout point, short of the restarted one
    cyc(15000);
    chk("restart delays timeout", 32'h0, {31'h0, wirq});
    wait_sig(0, 7000, n);
    chk("missed restart", 32'h1, {31'h0, wirq});
    wait_sig(1, 1100, n);
    near("reset delay", 1024, n, 4);
    wait_sig(2, 16200, n);
    near("reset length", 16128, n, 4);
    rd(OFS_WDCTL, d);
    chk("reset flag", 32'h1, {31'h0, d[WD_RSF]});
    wr(OFS_WDCTL, W_FLG);
    rd(OFS_WDCTL, d);
    chk("flags cleared", 32'h0, {28'h0, d[3:0]});
    wr(OFS_WDCTL, W_RUN | W_IRQ | W_TST | (32'h1 << WD_SLOW));
    wait_sig(0, 1100, n);
    near("split timeout", 1024, n, 4);
    wr(OFS_WDCTL, W_FLG);
    dbg = 1;
    wr(OFS_WDCTL, W_RUN | W_IRQ | W_TST);
    cyc(1500);
    chk("held by debug", 32'h0, {31'h0, wirq});
    wr(OFS_WDCTL, W_RUN | W_IRQ | W_TST | (32'h1 << WD_OVR));
    wait_sig(0, 1100, n);
    chk("debug override", 32'h1, {31'h0, wirq});
    dbg = 0;
    wr(OFS_WDCTL, W_FLG);
    wr(OFS_WDCTL, W_RUN | W_IRQ | (32'h1 << WD_SLOW));
    // Longer than an undivided timeout, so only the divider keeps it quiet
    cyc(17000);
    chk("slow clock", 32'h0, {31'h0, wirq});
    wr(OFS_WDCTL, W_RUN | W_IRQ | W_TST);
    cyc(600);
    wr(OFS_WDCTL, W_TST);
    wr(OFS_WDCTL, W_RUN | W_IRQ | W_TST);
    cyc(600);
    chk("stop clears count", 32'h0, {31'h0, wirq});
    wait_sig(0, 500, n);
    chk("count resumes", 32'h1, {31'h0, wirq});
    test_done();
  end
endmodule
`default_nettype wire
